// >>> switch_timer_pkg.sv
package switch_timer_pkg;

   // register addresses, 7-bit as carried in the serial frame
   localparam logic [6:0] ADDR_SECOND_CYCLE_TIMER      = 7'h0D;
   localparam logic [6:0] ADDR_FAULT_CTRL  = 7'h10;
   localparam logic [6:0] ADDR_PAIR_A      = 7'h14;
   localparam logic [6:0] ADDR_PAIR_B      = 7'h15;

   // reset value of all four registers
   localparam logic [7:0] REG_RESET        = 8'h00;

   // writable bits per register; everything else is reserved and reads zero
   localparam logic [7:0] MASK_SECOND_CYCLE_TIMER      = 8'h77;
   localparam logic [7:0] MASK_FAULT_CTRL  = 8'h70;
   localparam logic [7:0] MASK_PAIR        = 8'h77;

   // field positions
   localparam int unsigned ACTIVE_LSB      = 4;
   localparam int unsigned PERIOD_LSB      = 0;
   localparam int unsigned LOW_SRC_LSB     = 0;
   localparam int unsigned HIGH_SRC_LSB    = 4;
   localparam int unsigned OV_DIS_BIT      = 6;
   localparam int unsigned UV_DIS_BIT      = 5;
   localparam int unsigned RECOVER_BIT     = 4;

   // serial frame layout, least significant bit first on the wire
   localparam int unsigned FRAME_BITS      = 16;
   localparam int unsigned HEADER_BITS     = 8;
   localparam int unsigned RW_BIT          = 7;

   // switch source codes
   typedef enum logic [2:0] {
      SRC_OFF    = 3'h0,
      SRC_ON     = 3'h1,
      SRC_FIRST_CYCLE_TIMER = 3'h2,
      SRC_SECOND_CYCLE_TIMER = 3'h3,
      SRC_DUTY1  = 3'h4,
      SRC_DUTY2  = 3'h5
   } source_t;

   // active-time and period codes with a special meaning
   localparam logic [2:0] ACT_STOP_LOW     = 3'h0;
   localparam logic [2:0] ACT_STOP_HIGH    = 3'h6;
   localparam logic [2:0] ACT_RESERVED     = 3'h7;
   localparam logic [2:0] PER_RESERVED     = 3'h7;

   // timing: clock period and the timer base tick
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned TICK_NS         = 100000;
   localparam int unsigned TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // active times in microseconds, codes 1 to 5
   localparam int unsigned ACT1_US         = 100;
   localparam int unsigned ACT2_US         = 300;
   localparam int unsigned ACT3_US         = 1000;
   localparam int unsigned ACT4_US         = 10000;
   localparam int unsigned ACT5_US         = 20000;

   // periods in milliseconds, codes 0 to 6
   localparam int unsigned PER0_MS         = 10;
   localparam int unsigned PER1_MS         = 20;
   localparam int unsigned PER2_MS         = 50;
   localparam int unsigned PER3_MS         = 100;
   localparam int unsigned PER4_MS         = 200;
   localparam int unsigned PER5_MS         = 1000;
   localparam int unsigned PER6_MS         = 2000;

   // nanoseconds per microsecond and per millisecond, divided by the tick length to give ticks
   localparam int unsigned TICKS_PER_US_K  = 1000;
   localparam int unsigned TICKS_PER_MS_K  = 1000000;

   // active time in base ticks for a code; zero for codes without one
   function automatic logic [15:0] active_ticks(input logic [2:0] code);
      int unsigned us;
      us = 0;
      case (code)
         3'h1:    us = ACT1_US;
         3'h2:    us = ACT2_US;
         3'h3:    us = ACT3_US;
         3'h4:    us = ACT4_US;
         3'h5:    us = ACT5_US;
         default: us = 0;
      endcase
      return 16'((us * TICKS_PER_US_K) / TICK_NS);
   endfunction

   // period in base ticks for a code; zero for the reserved code
   function automatic logic [15:0] period_ticks(input logic [2:0] code);
      int unsigned ms;
      ms = 0;
      case (code)
         3'h0:    ms = PER0_MS;
         3'h1:    ms = PER1_MS;
         3'h2:    ms = PER2_MS;
         3'h3:    ms = PER3_MS;
         3'h4:    ms = PER4_MS;
         3'h5:    ms = PER5_MS;
         3'h6:    ms = PER6_MS;
         default: ms = 0;
      endcase
      return 16'((ms * TICKS_PER_MS_K) / TICK_NS);
   endfunction

endpackage

// >>> second_cycle_timer.sv
`timescale 1ns/10ps
module second_cycle_timer
#(
   parameter int unsigned TICK_CYCLES = switch_timer_pkg::TICK_CYCLES
)
(
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   // settings
   input  wire logic [2:0] active_code_i,
   input  wire logic [2:0] period_code_i,
   input  wire logic       assigned_i,
   input  wire logic       restart_i,
   // timer output level
   output logic            timer_o
);

   // one-hot timer states
   typedef enum logic [3:0] {
      T_IDLE_LOW  = 4'b0001,
      T_HOLD_HIGH = 4'b0010,
      T_ACTIVE    = 4'b0100,
      T_PAUSE     = 4'b1000
   } tstate_t;

   tstate_t     state_q;    // current phase
   tstate_t     state_d;    // next phase
   logic [15:0] count_q;    // ticks since period start
   logic [15:0] count_d;    // next tick count
   logic [15:0] pre_q;      // clock cycles within one tick
   logic        tick;       // one base tick elapsed
   logic [15:0] act_len;    // active length in ticks
   logic [15:0] per_len;    // period length in ticks
   logic        runnable;   // settings describe a running timer

   assign act_len  = switch_timer_pkg::active_ticks(active_code_i);
   assign per_len  = switch_timer_pkg::period_ticks(period_code_i);
   // reserved codes behave as stopped-low, except that active code 6 holds high even with the reserved period code
   assign runnable = assigned_i && (act_len != 16'h0000)
                     && (period_code_i != switch_timer_pkg::PER_RESERVED);
   assign tick     = (pre_q == 16'(TICK_CYCLES - 1));

   // base tick prescaler, restarted with the timer so phases stay aligned
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || restart_i || !runnable || state_q inside {T_IDLE_LOW, T_HOLD_HIGH})
         pre_q <= 16'h0000;
      else if (tick)
         pre_q <= 16'h0000;
      else
         pre_q <= pre_q + 16'h0001;
   end

   // phase sequencing
   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      if (active_code_i == switch_timer_pkg::ACT_STOP_HIGH)
      begin
         state_d = T_HOLD_HIGH;
         count_d = 16'h0000;
      end
      else if (!runnable)
      begin
         state_d = T_IDLE_LOW;
         count_d = 16'h0000;
      end
      else if (restart_i)
      begin
         state_d = T_ACTIVE;
         count_d = 16'h0000;
      end
      else
      begin
         case (state_q)
            T_IDLE_LOW, T_HOLD_HIGH:
            begin
               // settings just became valid: start a fresh period
               state_d = T_ACTIVE;
               count_d = 16'h0000;
            end
            T_ACTIVE:
            begin
               if (tick)
               begin
                  count_d = count_q + 16'h0001;
                  if (count_d >= act_len)
                     state_d = T_PAUSE;
               end
            end
            T_PAUSE:
            begin
               if (tick)
               begin
                  count_d = count_q + 16'h0001;
                  if (count_d >= per_len)
                  begin
                     state_d = T_ACTIVE;
                     count_d = 16'h0000;
                  end
               end
            end
            default:
            begin
               state_d = T_IDLE_LOW;
               count_d = 16'h0000;
            end
         endcase
      end
   end

   // phase registers
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         state_q <= T_IDLE_LOW;
         count_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

   // registered output level
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         timer_o <= 1'b0;
      else
         timer_o <= (state_d == T_ACTIVE) || (state_d == T_HOLD_HIGH);
   end

endmodule

// >>> serial_frame_port.sv
`timescale 1ns/10ps
module serial_frame_port
(
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   // serial pins, sampled on the system clock
   input  wire logic       sck_i,
   input  wire logic       cs_n_i,
   input  wire logic       mosi_i,
   output logic            miso_o,
   output logic            miso_oe_o,
   // register side
   output logic [6:0]      addr_o,
   input  wire logic [7:0] rd_data_i,
   output logic            wr_o,
   output logic [7:0]      wr_data_o
);

   logic        sck_q;      // previous clock sample
   logic        cs_n_q;     // previous select sample
   logic [4:0]  bits_q;     // bits received in this frame
   logic [15:0] in_q;       // received bits, first bit ends at bit 0
   logic [7:0]  out_q;      // bits still to send
   logic        rise;       // serial clock rising inside a frame
   logic        fall;       // serial clock falling inside a frame

   assign rise      = !cs_n_i && sck_i && !sck_q;
   assign fall      = !cs_n_i && !sck_i && sck_q;
   assign miso_oe_o = !cs_n_i;
   assign miso_o    = out_q[0];

   // edge history
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         sck_q  <= 1'b0;
         cs_n_q <= 1'b1;
      end
      else
      begin
         sck_q  <= sck_i;
         cs_n_q <= cs_n_i;
      end
   end

   // receive shifter, least significant bit first
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || (cs_n_q && !cs_n_i))
      begin
         bits_q <= 5'h00;
         in_q   <= 16'h0000;
      end
      else if (rise && bits_q != 5'(switch_timer_pkg::FRAME_BITS))
      begin
         bits_q <= bits_q + 5'h01;
         in_q   <= {mosi_i, in_q[15:1]};
      end
   end

   // address latched once the header byte is in
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         addr_o <= 7'h00;
      else if (bits_q == 5'(switch_timer_pkg::HEADER_BITS) && !cs_n_i && out_q == 8'h00)
         addr_o <= in_q[14:8];
   end

   // transmit shifter: zeros during the header, then old register content
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || cs_n_i)
         out_q <= 8'h00;
      else if (fall && bits_q == 5'(switch_timer_pkg::HEADER_BITS))
         out_q <= rd_data_i;
      else if (fall)
         out_q <= {1'b0, out_q[7:1]};
   end

   // write strobe when a full frame ends with the write flag set
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         wr_o      <= 1'b0;
         wr_data_o <= 8'h00;
      end
      else
      begin
         wr_o      <= !cs_n_q && cs_n_i && bits_q == 5'(switch_timer_pkg::FRAME_BITS)
                      && in_q[switch_timer_pkg::RW_BIT];
         wr_data_o <= in_q[15:8];
      end
   end

endmodule

// >>> switch_timer_control.sv
// Functional notes
// - active-time codes 0 to 5 select low or times
// - code 6 holds timer output high; 7 invalid
// - period codes 0 to 6 select 10ms..2s
// - timer starts when active time written, if assigned
// - restart clear under cyclic sense clears timer fields
// - reserved bits ignore writes, read zero
// - overvoltage shuts switches unless bit 6 set
// - undervoltage shuts switches unless bit 5 set
// - bit 4 restores pre-fault states after fault
// - source codes: off, on, timers, duty generators
// - switch fields at bits 2:0 and 6:4
// - overcurrent or overtemperature clears source field
// - all registers zero after power-on or soft reset
`timescale 1ns/10ps
module switch_timer_control
#(
   parameter int unsigned TICK_CYCLES = switch_timer_pkg::TICK_CYCLES,
   parameter int unsigned SWITCHES    = 4
)
(
   // clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                reset_i,
   input  wire logic                soft_reset_i,
   // serial register port
   input  wire logic                sck_i,
   input  wire logic                cs_n_i,
   input  wire logic                mosi_i,
   output logic                     miso_o,
   output logic                     miso_oe_o,
   // drive sources from elsewhere in the chip
   input  wire logic                first_cycle_timer_i,
   input  wire logic                first_duty_generator_i,
   input  wire logic                second_duty_generator_i,
   // supply and switch protection
   input  wire logic                supply_over_volt_i,
   input  wire logic                supply_under_volt_i,
   input  wire logic [SWITCHES-1:0] over_current_i,
   input  wire logic [SWITCHES-1:0] over_temp_i,
   // restart handling
   input  wire logic                restart_clear_i,
   input  wire logic                cyclic_sense_i,
   // switch drive, timer level and supply cutoff state
   output logic [SWITCHES-1:0]      switch_output_o,
   output logic                     second_cycle_timer_o,
   output logic                     supply_cutoff_o
);

   // register storage
   logic [7:0] second_cycle_timer_q;     // active time and period
   logic [7:0] fault_q;      // supply fault behaviour
   logic [7:0] pair_a_q;     // switches 1 and 2
   logic [7:0] pair_b_q;     // switches 3 and 4

   // serial port side
   logic [6:0] addr;         // addressed register
   logic       wr;           // one-cycle write strobe
   logic [7:0] wr_data;      // byte to write
   logic [7:0] rd_data;      // content of addressed register

   // derived controls
   logic       clear_all;    // soft reset clears the whole bank
   logic       timer_write;  // timer register written this cycle
   logic       timer_clear;  // restart clear wipes the timer fields
   logic       shut_now;     // supply fault currently forces switches off
   logic       shut_q;       // shut state one cycle ago
   logic       fault_entry;  // first cycle of a supply shutdown
   logic       second_cycle_timer_used;  // some switch runs from the second timer

   // per-switch source fields, one view of both pair registers
   logic [2:0] src   [SWITCHES];
   logic       drive [SWITCHES];

   // field views; the bank order follows the pair registers
   assign src[0] = pair_a_q[switch_timer_pkg::LOW_SRC_LSB  +: 3];
   assign src[1] = pair_a_q[switch_timer_pkg::HIGH_SRC_LSB +: 3];
   assign src[2] = pair_b_q[switch_timer_pkg::LOW_SRC_LSB  +: 3];
   assign src[3] = pair_b_q[switch_timer_pkg::HIGH_SRC_LSB +: 3];

   assign clear_all   = reset_i || soft_reset_i;
   assign timer_write = wr && addr == switch_timer_pkg::ADDR_SECOND_CYCLE_TIMER;
   assign timer_clear = restart_clear_i && cyclic_sense_i;

   // supply fault shutdown, each cause gated by its own disable bit
   assign shut_now =
      (supply_over_volt_i  && !fault_q[switch_timer_pkg::OV_DIS_BIT]) ||
      (supply_under_volt_i && !fault_q[switch_timer_pkg::UV_DIS_BIT]);
   assign fault_entry = shut_now && !shut_q;

   // serial frame decoder
   serial_frame_port u_port
   (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .sck_i     (sck_i),
      .cs_n_i    (cs_n_i),
      .mosi_i    (mosi_i),
      .miso_o    (miso_o),
      .miso_oe_o (miso_oe_o),
      .addr_o    (addr),
      .rd_data_i (rd_data),
      .wr_o      (wr),
      .wr_data_o (wr_data)
   );

   // the timer only runs while at least one switch is tied to it
   always_comb
   begin
      second_cycle_timer_used = 1'b0;
      for (int i = 0; i < SWITCHES; i++)
      begin
         if (src[i] == switch_timer_pkg::SRC_SECOND_CYCLE_TIMER)
            second_cycle_timer_used = 1'b1;
      end
   end

   // second cycle timer; a write restarts it from the active phase
   second_cycle_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_second_cycle_timer (
      .clk_sys_i     (clk_sys_i),
      .reset_i       (clear_all),
      .active_code_i (second_cycle_timer_q[switch_timer_pkg::ACTIVE_LSB +: 3]),
      .period_code_i (second_cycle_timer_q[switch_timer_pkg::PERIOD_LSB +: 3]),
      .assigned_i    (second_cycle_timer_used),
      .restart_i     (timer_write),
      .timer_o       (second_cycle_timer_o)
   );

   // read multiplexer; unknown addresses read zero
   always_comb
   begin
      case (addr)
         switch_timer_pkg::ADDR_SECOND_CYCLE_TIMER:     rd_data = second_cycle_timer_q & switch_timer_pkg::MASK_SECOND_CYCLE_TIMER;
         switch_timer_pkg::ADDR_FAULT_CTRL: rd_data = fault_q & switch_timer_pkg::MASK_FAULT_CTRL;
         switch_timer_pkg::ADDR_PAIR_A:     rd_data = pair_a_q & switch_timer_pkg::MASK_PAIR;
         switch_timer_pkg::ADDR_PAIR_B:     rd_data = pair_b_q & switch_timer_pkg::MASK_PAIR;
         default:                           rd_data = 8'h00;
      endcase
   end

   // timer register; the restart clear beats a write in the same cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (clear_all)
         second_cycle_timer_q <= switch_timer_pkg::REG_RESET;
      else if (timer_clear)
         second_cycle_timer_q <= switch_timer_pkg::REG_RESET;
      else if (timer_write)
         second_cycle_timer_q <= wr_data & switch_timer_pkg::MASK_SECOND_CYCLE_TIMER;
   end

   // supply fault control register, plain read/write
   always_ff @(posedge clk_sys_i)
   begin
      if (clear_all)
         fault_q <= switch_timer_pkg::REG_RESET;
      else if (wr && addr == switch_timer_pkg::ADDR_FAULT_CTRL)
         fault_q <= wr_data & switch_timer_pkg::MASK_FAULT_CTRL;
   end

   // shutdown history, to find the first cycle of a fault
   always_ff @(posedge clk_sys_i)
   begin
      if (clear_all)
         shut_q <= 1'b0;
      else
         shut_q <= shut_now;
   end

   // pair registers: software writes, hardware clears per switch.
   // a hardware clear wins over a write in the same cycle, so a
   // protected switch never comes back on through a racing write.
   always_ff @(posedge clk_sys_i)
   begin
      if (clear_all)
      begin
         pair_a_q <= switch_timer_pkg::REG_RESET;
         pair_b_q <= switch_timer_pkg::REG_RESET;
      end
      else if (restart_clear_i)
      begin
         // restart clear wipes every source field
         pair_a_q <= switch_timer_pkg::REG_RESET;
         pair_b_q <= switch_timer_pkg::REG_RESET;
      end
      else if (fault_entry && !fault_q[switch_timer_pkg::RECOVER_BIT])
      begin
         // no recovery wanted: the pre-fault states are forgotten
         pair_a_q <= switch_timer_pkg::REG_RESET;
         pair_b_q <= switch_timer_pkg::REG_RESET;
      end
      else
      begin
         if (wr && addr == switch_timer_pkg::ADDR_PAIR_A)
            pair_a_q <= wr_data & switch_timer_pkg::MASK_PAIR;
         if (wr && addr == switch_timer_pkg::ADDR_PAIR_B)
            pair_b_q <= wr_data & switch_timer_pkg::MASK_PAIR;
         if (over_current_i[0] || over_temp_i[0])
            pair_a_q[switch_timer_pkg::LOW_SRC_LSB +: 3] <= 3'h0;
         if (over_current_i[1] || over_temp_i[1])
            pair_a_q[switch_timer_pkg::HIGH_SRC_LSB +: 3] <= 3'h0;
         if (over_current_i[2] || over_temp_i[2])
            pair_b_q[switch_timer_pkg::LOW_SRC_LSB +: 3] <= 3'h0;
         if (over_current_i[3] || over_temp_i[3])
            pair_b_q[switch_timer_pkg::HIGH_SRC_LSB +: 3] <= 3'h0;
      end
   end

   // per-switch source selection
   generate
      for (genvar g = 0; g < SWITCHES; g++)
      begin : g_sel
         always_comb
         begin
            case (src[g])
               switch_timer_pkg::SRC_OFF:    drive[g] = 1'b0;
               switch_timer_pkg::SRC_ON:     drive[g] = 1'b1;
               switch_timer_pkg::SRC_FIRST_CYCLE_TIMER: drive[g] = first_cycle_timer_i;
               switch_timer_pkg::SRC_SECOND_CYCLE_TIMER: drive[g] = second_cycle_timer_o;
               switch_timer_pkg::SRC_DUTY1:  drive[g] = first_duty_generator_i;
               switch_timer_pkg::SRC_DUTY2:  drive[g] = second_duty_generator_i;
               default:                      drive[g] = 1'b0;
            endcase
         end

         // registered drive; held low while supply shutdown or protection acts.
         // with recovery on, the source field survives a supply fault, so the switch
         // resumes by itself once the fault is gone
         always_ff @(posedge clk_sys_i)
         begin
            if (clear_all)
               switch_output_o[g] <= 1'b0;
            else if (shut_now || over_current_i[g] || over_temp_i[g])
               switch_output_o[g] <= 1'b0;
            else
               switch_output_o[g] <= drive[g];
         end
      end
   endgenerate

   // visible shutdown state for the rest of the chip
   always_ff @(posedge clk_sys_i)
   begin
      if (clear_all)
         supply_cutoff_o <= 1'b0;
      else
         supply_cutoff_o <= shut_now;
   end

endmodule

// >>> switch_timer_properties.sv
`timescale 1ns/10ps
module switch_timer_properties
#(
   parameter int unsigned SWITCHES = 4
)
(
   // clock and resets
   input wire logic                clk_sys_i,
   input wire logic                reset_i,
   input wire logic                soft_reset_i,
   // supply, protection and restart
   input wire logic                supply_over_volt_i,
   input wire logic                supply_under_volt_i,
   input wire logic [SWITCHES-1:0] over_current_i,
   input wire logic [SWITCHES-1:0] over_temp_i,
   input wire logic                restart_clear_i,
   // drive outputs
   input wire logic [SWITCHES-1:0] switch_output_o,
   input wire logic                second_cycle_timer_o,
   input wire logic                supply_cutoff_o
);
   // one clock domain, so one default for all checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   chk_cutoff_blocks_drive: assert property (supply_cutoff_o && $past(supply_cutoff_o)
      |-> switch_output_o == '0) else $error("switch driven during supply cutoff");
   chk_cutoff_needs_fault: assert property (supply_cutoff_o
      |-> $past(supply_over_volt_i || supply_under_volt_i)) else $error("cutoff without fault");
   chk_cutoff_lifts_clean: assert property (!$past(supply_over_volt_i)
      && !$past(supply_under_volt_i) |-> !supply_cutoff_o) else $error("cutoff stays");
   chk_overcurrent_off: assert property
      (($past(over_current_i) & switch_output_o) == '0) else $error("overcurrent switch on");
   chk_overtemp_off: assert property
      (($past(over_temp_i) & switch_output_o) == '0) else $error("overtemp switch on");
   chk_soft_reset_off: assert property (soft_reset_i [*3]
      |=> switch_output_o == '0) else $error("switch on after soft reset");
   chk_soft_reset_timer: assert property (soft_reset_i [*3]
      |=> !second_cycle_timer_o) else $error("timer high after soft reset");
   chk_restart_clears: assert property (restart_clear_i [*3]
      |=> switch_output_o == '0) else $error("switch on after restart clear");
endmodule

bind switch_timer_control switch_timer_properties #(.SWITCHES(SWITCHES)) switch_timer_properties_inst
(
   .clk_sys_i, .reset_i, .soft_reset_i, .supply_over_volt_i, .supply_under_volt_i,
   .over_current_i, .over_temp_i, .restart_clear_i, .switch_output_o,
   .second_cycle_timer_o, .supply_cutoff_o
);

// >>> tb_switch_timer_control.sv
`timescale 1ns/10ps
module tb_switch_timer_control;
   localparam int TICK = 4;   // short tick keeps timer periods to a few hundred cycles
   logic       clk_sys_i, reset_i, soft_reset_i, sck_i, cs_n_i, mosi_i, miso_o, miso_oe_o;
   logic       first_cycle_timer_i, first_duty_generator_i, second_duty_generator_i;
   logic       supply_over_volt_i, supply_under_volt_i, restart_clear_i, cyclic_sense_i;
   logic       second_cycle_timer_o, supply_cutoff_o;
   logic [3:0] over_current_i, over_temp_i, switch_output_o;
   logic [7:0] rd;                                         // last read byte
   logic [7:0] m [4];                                      // register model
   logic [6:0] ad [4] = '{7'h0D, 7'h10, 7'h14, 7'h15};     // register addresses
   logic [7:0] k  [4] = '{8'h77, 8'h70, 8'h77, 8'h77};     // writable bits
   int         error_cnt, checks_done, cyc_cnt, n;

   switch_timer_control #(.TICK_CYCLES(TICK), .SWITCHES(4)) switch_timer_control_inst
   (
      .clk_sys_i, .reset_i, .soft_reset_i, .sck_i, .cs_n_i, .mosi_i, .miso_o, .miso_oe_o,
      .first_cycle_timer_i, .first_duty_generator_i, .second_duty_generator_i,
      .supply_over_volt_i, .supply_under_volt_i, .over_current_i, .over_temp_i,
      .restart_clear_i, .cyclic_sense_i, .switch_output_o, .second_cycle_timer_o,
      .supply_cutoff_o
   );

   initial
   begin
      clk_sys_i = 0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic summarize();
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // hang guard, well above the roughly 5800 cycles the run needs
   always @(posedge clk_sys_i)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end

   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge clk_sys_i);
   endtask

   // one 16-bit frame, lsb first; sck phases of 3 clocks each
   task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] wd);
      logic [15:0] f;
      f = {wd, w, a};
      cs_n_i = 0;
      for (int i = 0; i < 16; i++)
      begin
         mosi_i = f[i];
         cyc(3);
         if (i > 7)
            rd[i-8] = miso_o;
         sck_i = 1;
         cyc(3);
         sck_i = 0;
      end
      cyc(3);
      cmp(8'(miso_oe_o), 8'h01);
      cs_n_i = 1;
      cyc(5);   // register plus registered output settle
   endtask

   task automatic wr(input int r, input logic [7:0] v);
      frame(ad[r], 1'b1, v);
      m[r] = v & k[r];
   endtask

   task automatic chk_reg(input int r);
      frame(ad[r], 1'b0, 8'h00);
      cmp(rd, m[r]);
   endtask

   // expected level of one switch; timer is only used while held high
   function automatic logic sel(input logic [2:0] c);
      case (c)
         3'h1:    return 1'b1;
         3'h2:    return first_cycle_timer_i;
         3'h3:    return m[0][6:4] == 3'h6;
         3'h4:    return first_duty_generator_i;
         3'h5:    return second_duty_generator_i;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] expv();
      return {4'h0, sel(m[3][6:4]), sel(m[3][2:0]), sel(m[2][6:4]), sel(m[2][2:0])};
   endfunction

   initial
   begin
      {reset_i, soft_reset_i, sck_i, cs_n_i, mosi_i} = 5'h12;
      {first_cycle_timer_i, first_duty_generator_i, second_duty_generator_i} = 3'h0;
      {supply_over_volt_i, supply_under_volt_i, restart_clear_i, cyclic_sense_i} = 4'h0;
      over_current_i = 4'h0;
      over_temp_i = 4'h0;
      m = '{default: 8'h00};
      void'($urandom(83334));
      cyc(16);
      reset_i = 0;
      cyc(2);
      for (int r = 0; r < 4; r++)
         chk_reg(r);
      frame(7'h20, 1'b1, 8'($urandom));
      frame(7'h20, 1'b0, 8'h00);
      cmp(rd, 8'h00);
      for (int r = 0; r < 4; r++)
      begin
         wr(r, 8'($urandom));
         chk_reg(r);
      end
      soft_reset_i = 1;
      cyc(4);
      soft_reset_i = 0;
      m = '{default: 8'h00};
      for (int r = 0; r < 4; r++)
         chk_reg(r);
      // every source code on all four switches, timer held high
      wr(0, 8'h60);
      for (int c = 0; c < 8; c++)
      begin
         {first_cycle_timer_i, first_duty_generator_i, second_duty_generator_i} = 3'($urandom);
         wr(2, {1'b0, 3'(c), 1'b0, 3'(c)});
         wr(3, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
         cmp(8'(switch_output_o), expv());
         cmp(8'(second_cycle_timer_o), 8'h01);
      end
      // running timer: 0.3 ms high in each 10 ms period, two periods counted
      wr(2, 8'h03);
      wr(3, 8'h00);
      wr(0, 8'h20);
      n = 0;
      repeat (800)
      begin
         cyc(1);
         if (second_cycle_timer_o === 1'b1)
            n++;
      end
      cmp(8'(n), 8'(2 * 3 * TICK));
      cyclic_sense_i = 1;
      restart_clear_i = 1;
      cyc(4);
      {restart_clear_i, cyclic_sense_i} = 2'h0;
      m[0] = 8'h00;
      m[2] = 8'h00;
      chk_reg(0);
      chk_reg(2);
      // protection clears only the faulty switch
      wr(2, 8'h11);
      wr(3, 8'h11);
      over_current_i = 4'h2;
      over_temp_i = 4'h4;
      cyc(3);
      over_current_i = 4'h0;
      over_temp_i = 4'h0;
      m[2] = 8'h01;
      m[3] = 8'h10;
      chk_reg(2);
      chk_reg(3);
      cmp(8'(switch_output_o), expv());
      // supply faults: cutoff without recovery, then masked and recovered
      supply_over_volt_i = 1;
      cyc(3);
      cmp(8'(switch_output_o), 8'h00);
      cmp(8'(supply_cutoff_o), 8'h01);
      supply_over_volt_i = 0;
      cyc(3);
      m[2] = 8'h00;
      m[3] = 8'h00;
      chk_reg(2);
      wr(1, 8'h50);
      wr(2, 8'h01);
      supply_over_volt_i = 1;
      cyc(3);
      cmp(8'(switch_output_o), expv());
      supply_under_volt_i = 1;
      cyc(3);
      cmp(8'(switch_output_o), 8'h00);
      {supply_over_volt_i, supply_under_volt_i} = 2'h0;
      cyc(3);
      cmp(8'(switch_output_o), expv());
      chk_reg(2);
      summarize();
   end
endmodule
